// ==== shared/mcs_pkg.sv ====
// Constants and types of the motion card supervisor
package mcs_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_INPUTS = 8'h0C;
	localparam logic [7:0] ADDR_INPUTS_N = 8'h10;
	localparam logic [7:0] ADDR_NODES = 8'h14;
	////////////////////////////////////////////////////////////////////////
	// Control bits
	localparam int CTRL_WD_EN = 0;
	localparam int CTRL_PWR_REQ = 1;
	localparam int CTRL_APP_RUN = 2;
	localparam int CTRL_RESCAN = 3;
	localparam int CTRL_CLR_BUS_ERR = 4;
	// Status bits
	localparam int ST_WD_EXP = 0;
	localparam int ST_PWR_FAULT = 1;
	localparam int ST_PWR_EN = 2;
	localparam int ST_BUS_ERR = 3;
	localparam int ST_SCAN_INIT = 4;
	// Input register fields
	localparam int IN_LOWER_LSB = 0;
	localparam int IN_UPPER_LSB = 6;
	localparam int IN_REF_LSB = 12;
	localparam int IN_ESTOP_LSB = 18;
	localparam int IN_WIDTH = 20;
	// Node register fields
	localparam int NODE_PRESENT_LSB = 0;
	localparam int NODE_DROPPED_LSB = 16;
	////////////////////////////////////////////////////////////////////////
	// Sizes and reset values
	localparam int NUM_JOINTS = 6;
	localparam int NUM_ESTOP = 2;
	localparam int NUM_PWR = 7;
	localparam int NUM_NODES = 16;
	localparam int NODE_AW = 4;
	localparam logic [1:0] MISS_LIMIT = 2'h3;
	localparam logic [31:0] TIMEOUT_RESET = 32'h000F_4240;
	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;
	localparam int unsigned POLL_US = 50;
	localparam int unsigned POLL_CYCLES = POLL_US * CLK_MHZ;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic {MCS_SCAN_INIT, MCS_SCAN_RUN} mcs_scan_t;
endpackage

// ==== src/mcs_top.sv ====
// Watchdog, switch sampling, indicators and expander supervision
`timescale 1ns/1ps
// Overview of operation
// - Reading the input register restarts the watchdog count.
// - Watchdog expiry forces all power-enable outputs low in hardware.
// - Status register shows a bit set once the watchdog expired.
// - Writable watchdog enable; while clear it never expires.
// - Writable timeout: longest interval between two input reads.
// - Six joints: lower, upper, reference switches read true and inverted.
// - Two emergency-stop inputs read true and inverted.
// - CAN light blinks on traffic, lit on full buffer, else dark.
// - RS485 light blinks in init, lit all good, dark on drop.
// - Host activity light blinks while host application runs.
// - Boot light lit once card finished booting.
// - Error light dark, blinks on bus error, lit on expiry.
// - Every answering expander node is recognised automatically.
// - Node that stops answering is dropped from the active set.
// - Nodes carry unique four-bit addresses, polled by that value.
// - Power enable only with request, no expiry, no power fault.
module mcs_top
	import mcs_pkg::*;
#(
	parameter int unsigned BLINK_HALF = BLINK_HALF_CYCLES,
	parameter int unsigned POLL_PERIOD = POLL_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_JOINTS-1:0] joint_lower_limit,
	input wire logic [NUM_JOINTS-1:0] joint_upper_limit,
	input wire logic [NUM_JOINTS-1:0] joint_reference_switch,
	input wire logic [NUM_ESTOP-1:0] estop_in,
	input wire logic power_fault,
	output logic [NUM_PWR-1:0] power_enable,
	input wire logic can_frame,
	input wire logic can_buffer_full,
	input wire logic host_bus_error,
	input wire logic node_answer,
	input wire logic [NODE_AW-1:0] node_answer_addr,
	output logic node_poll,
	output logic [NODE_AW-1:0] node_poll_addr,
	output logic led_can,
	output logic led_rs485,
	output logic host_activity_indicator,
	output logic led_boot,
	output logic led_error
);
	////////////////////////////////////////////////////////////////////////
	// Bus slave and registers
	logic wd_en, pwr_req, app_run, bus_err, pf_smp;
	logic [31:0] timeout, rd_val;
	logic [IN_WIDTH-1:0] in_smp;
	logic next_wd_en, next_pwr_req, next_app_run, next_bus_err;
	logic next_pready, next_pslverr, addr_hit;
	logic [31:0] next_timeout, next_prdata;
	logic setup, access, wr_ctrl, cfg_wr, refresh;
	logic wd_exp, next_wd_exp, wd_set;
	logic [31:0] wd_cnt, next_wd_cnt;
	logic [NUM_PWR-1:0] next_pwr;
	mcs_scan_t scan_st, next_scan_st;
	logic [NUM_NODES-1:0] present, dropped, next_present, next_dropped;
	logic [1:0] miss [NUM_NODES];
	logic [1:0] next_miss [NUM_NODES];
	logic [31:0] poll_tmr, next_poll_tmr;
	logic [NODE_AW-1:0] next_poll_addr;
	logic answered, next_answered, next_node_poll, tick, hit, rescan;

	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign wr_ctrl = access && pwrite && paddr == ADDR_CTRL;
	assign cfg_wr = access && pwrite &&
		(paddr == ADDR_CTRL || paddr == ADDR_TIMEOUT);
	assign refresh = access && !pwrite && paddr == ADDR_INPUTS;
	assign rescan = wr_ctrl && pwdata[CTRL_RESCAN];

	always_comb begin
		rd_val = 32'h0000_0000;
		addr_hit = 1'b1;
		case (paddr)
			ADDR_CTRL: begin
				rd_val[CTRL_WD_EN] = wd_en;
				rd_val[CTRL_PWR_REQ] = pwr_req;
				rd_val[CTRL_APP_RUN] = app_run;
			end
			ADDR_TIMEOUT: rd_val = timeout;
			ADDR_STATUS: begin
				rd_val[ST_WD_EXP] = wd_exp;
				rd_val[ST_PWR_FAULT] = pf_smp;
				rd_val[ST_PWR_EN] = power_enable[0];
				rd_val[ST_BUS_ERR] = bus_err;
				rd_val[ST_SCAN_INIT] = scan_st == MCS_SCAN_INIT;
			end
			ADDR_INPUTS: rd_val[IN_WIDTH-1:0] = in_smp;
			ADDR_INPUTS_N: rd_val[IN_WIDTH-1:0] = ~in_smp;
			ADDR_NODES: rd_val = {dropped, present};
			default: addr_hit = 1'b0;
		endcase
		next_pready = setup;
		next_pslverr = setup && !addr_hit;
		next_prdata = (setup && !pwrite) ? rd_val : prdata;
		next_wd_en = wd_en;
		next_pwr_req = pwr_req;
		next_app_run = app_run;
		next_timeout = timeout;
		if (wr_ctrl) begin
			next_wd_en = pwdata[CTRL_WD_EN];
			next_pwr_req = pwdata[CTRL_PWR_REQ];
			next_app_run = pwdata[CTRL_APP_RUN];
		end
		if (access && pwrite && paddr == ADDR_TIMEOUT) begin
			next_timeout = pwdata;
		end
		next_bus_err = host_bus_error ||
			(bus_err && !(wr_ctrl && pwdata[CTRL_CLR_BUS_ERR]));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			wd_en <= 1'b0;
			pwr_req <= 1'b0;
			app_run <= 1'b0;
			timeout <= TIMEOUT_RESET;
			bus_err <= 1'b0;
			in_smp <= '0;
			pf_smp <= 1'b0;
		end else if (ce) begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			wd_en <= next_wd_en;
			pwr_req <= next_pwr_req;
			app_run <= next_app_run;
			timeout <= next_timeout;
			bus_err <= next_bus_err;
			in_smp <= {estop_in, joint_reference_switch, joint_upper_limit,
				joint_lower_limit};
			pf_smp <= power_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog and power enables
	assign wd_set = wd_en && next_wd_en && !refresh && wd_cnt > timeout;

	always_comb begin
		if (!wd_en || refresh || cfg_wr) begin
			next_wd_cnt = 32'h0000_0000;
		end else if (wd_cnt != 32'hFFFF_FFFF) begin
			next_wd_cnt = wd_cnt + 32'h0000_0001;
		end else begin
			next_wd_cnt = wd_cnt;
		end
		next_wd_exp = wd_set || (wd_exp && !cfg_wr);
		next_pwr = {NUM_PWR{pwr_req && !next_wd_exp && !pf_smp}};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_cnt <= 32'h0000_0000;
			wd_exp <= 1'b0;
			power_enable <= '0;
		end else if (ce) begin
			wd_cnt <= next_wd_cnt;
			wd_exp <= next_wd_exp;
			power_enable <= next_pwr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expander node scan
	assign tick = poll_tmr == POLL_PERIOD - 1;
	assign hit = answered ||
		(node_answer && node_answer_addr == node_poll_addr);

	always_comb begin
		next_poll_tmr = tick ? 32'h0000_0000 : poll_tmr + 32'h0000_0001;
		next_poll_addr = node_poll_addr;
		next_answered = hit;
		next_node_poll = 1'b0;
		next_present = present;
		next_dropped = dropped;
		next_miss = miss;
		next_scan_st = scan_st;
		if (tick) begin
			next_answered = 1'b0;
			next_node_poll = 1'b1;
			next_poll_addr = node_poll_addr + 4'h1;
			if (hit) begin
				next_present[node_poll_addr] = 1'b1;
				next_dropped[node_poll_addr] = 1'b0;
				next_miss[node_poll_addr] = 2'h0;
			end else if (present[node_poll_addr]) begin
				if (miss[node_poll_addr] == MISS_LIMIT - 2'h1) begin
					next_present[node_poll_addr] = 1'b0;
					next_dropped[node_poll_addr] = 1'b1;
					next_miss[node_poll_addr] = 2'h0;
				end else begin
					next_miss[node_poll_addr] = miss[node_poll_addr] + 2'h1;
				end
			end
			if (node_poll_addr == 4'hF) begin
				next_scan_st = MCS_SCAN_RUN;
			end
		end
		if (rescan) begin
			next_scan_st = MCS_SCAN_INIT;
			next_present = '0;
			next_dropped = '0;
			next_poll_addr = 4'h0;
			next_poll_tmr = 32'h0000_0000;
			next_answered = 1'b0;
			for (int i = 0; i < NUM_NODES; i++) begin
				next_miss[i] = 2'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_st <= MCS_SCAN_INIT;
			present <= '0;
			dropped <= '0;
			poll_tmr <= 32'h0000_0000;
			node_poll_addr <= 4'h0;
			answered <= 1'b0;
			node_poll <= 1'b0;
			for (int i = 0; i < NUM_NODES; i++) begin
				miss[i] <= 2'h0;
			end
		end else if (ce) begin
			scan_st <= next_scan_st;
			present <= next_present;
			dropped <= next_dropped;
			poll_tmr <= next_poll_tmr;
			node_poll_addr <= next_poll_addr;
			answered <= next_answered;
			node_poll <= next_node_poll;
			miss <= next_miss;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indicators
	logic [31:0] blink_cnt, next_blink_cnt;
	logic blink, next_blink, can_seen, next_can_seen, can_act, next_can_act;
	logic next_led_can, next_led_rs485, next_led_host, next_led_error;

	always_comb begin
		next_blink_cnt = blink_cnt + 32'h0000_0001;
		next_blink = blink;
		next_can_seen = can_seen || can_frame;
		next_can_act = can_act;
		if (blink_cnt == BLINK_HALF - 1) begin
			next_blink_cnt = 32'h0000_0000;
			next_blink = !blink;
			next_can_act = can_seen || can_frame;
			next_can_seen = 1'b0;
		end
		next_led_can = can_buffer_full || (can_act && blink);
		case (scan_st)
			MCS_SCAN_INIT: next_led_rs485 = blink;
			MCS_SCAN_RUN: next_led_rs485 = ~|dropped;
			default: next_led_rs485 = 1'b0;
		endcase
		next_led_host = app_run && blink;
		next_led_error = wd_exp || (bus_err && blink);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt <= 32'h0000_0000;
			blink <= 1'b0;
			can_seen <= 1'b0;
			can_act <= 1'b0;
			led_can <= 1'b0;
			led_rs485 <= 1'b0;
			host_activity_indicator <= 1'b0;
			led_boot <= 1'b0;
			led_error <= 1'b0;
		end else if (ce) begin
			blink_cnt <= next_blink_cnt;
			blink <= next_blink;
			can_seen <= next_can_seen;
			can_act <= next_can_act;
			led_can <= next_led_can;
			led_rs485 <= next_led_rs485;
			host_activity_indicator <= next_led_host;
			led_boot <= 1'b1;
			led_error <= next_led_error;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence seq_rd_setup(logic [7:0] a);
		ce && psel && !penable && !pwrite && paddr == a;
	endsequence
	sequence seq_node_lost;
		ce && tick && !rescan && !hit && present[node_poll_addr] &&
			miss[node_poll_addr] == MISS_LIMIT - 2'h1;
	endsequence

	AST_WD_REFRESH: assert property (@(posedge pclk) disable iff (!presetn)
		ce && refresh |=> wd_cnt == 32'h0000_0000)
		else $error("watchdog count not restarted by input read");
	AST_PWR_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		wd_exp |-> power_enable == '0)
		else $error("power enable high while watchdog expired");
	AST_EXP_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
		seq_rd_setup(ADDR_STATUS) |=> prdata[ST_WD_EXP] == $past(wd_exp))
		else $error("status does not show watchdog expiry");
	AST_WD_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!wd_en |-> !wd_exp)
		else $error("watchdog expired while disabled");
	AST_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn)
		ce && wd_en && next_wd_en && !refresh && wd_cnt > timeout |=> wd_exp)
		else $error("watchdog did not expire past timeout");
	AST_INPUTS_N: assert property (@(posedge pclk) disable iff (!presetn)
		seq_rd_setup(ADDR_INPUTS_N) |=> prdata[17:0] == ~$past(in_smp[17:0]))
		else $error("inverted joint switches wrong");
	AST_ESTOP: assert property (@(posedge pclk) disable iff (!presetn)
		seq_rd_setup(ADDR_INPUTS) |=> prdata[19:18] == $past(in_smp[19:18]))
		else $error("emergency stop bits wrong");
	AST_CAN_FULL: assert property (@(posedge pclk) disable iff (!presetn)
		ce && can_buffer_full |=> led_can)
		else $error("CAN light not lit on full buffer");
	AST_RS485_DARK: assert property (@(posedge pclk) disable iff (!presetn)
		ce && scan_st == MCS_SCAN_RUN && |dropped |=> !led_rs485)
		else $error("RS485 light lit with dropped node");
	AST_HOST_LED: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !app_run |=> !host_activity_indicator)
		else $error("host light active without application");
	AST_ERR_LIT: assert property (@(posedge pclk) disable iff (!presetn)
		ce && wd_exp && !cfg_wr |=> led_error [*2])
		else $error("error light not lit on expiry");
	AST_FOUND: assert property (@(posedge pclk) disable iff (!presetn)
		ce && tick && hit && !rescan |=> present[$past(node_poll_addr)])
		else $error("answering node not recognised");
	AST_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		seq_node_lost |=> !present[$past(node_poll_addr)] &&
			dropped[$past(node_poll_addr)])
		else $error("silent node not dropped");
	AST_PWR_COND: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> power_enable[0] == ($past(pwr_req) && !wd_exp && !$past(pf_smp)))
		else $error("power enable condition wrong");
	AST_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
		ce && wd_exp && !cfg_wr |=> wd_exp)
		else $error("watchdog expiry released without rewrite");
endmodule

// ==== dv/mcs_node_model.sv ====
// Expander node model: answers polls of its own address after a delay
`timescale 1ns/1ps
module mcs_node_model
	import mcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic node_poll,
	input wire logic [NODE_AW-1:0] node_poll_addr,
	input wire logic [NUM_NODES-1:0] present_mask,
	input wire logic [3:0] delay,
	output logic node_answer,
	output logic [NODE_AW-1:0] node_answer_addr
);
	logic [3:0] cnt;
	logic [NODE_AW-1:0] pend;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			pend <= '0;
			node_answer <= 1'b0;
			node_answer_addr <= '0;
		end else begin
			node_answer <= 1'b0;
			// Idle bus shows a changing pattern, not the last address
			node_answer_addr <= ~node_answer_addr;
			cnt <= (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
			// Only nodes in the mask answer, each by its own address
			// Masked-out nodes stand for nodes in error state: silent
			if (node_poll && present_mask[node_poll_addr]) begin
				cnt <= delay;
				pend <= node_poll_addr;
			end else if (cnt == 4'h1) begin
				node_answer <= 1'b1;
				node_answer_addr <= pend;
			end
		end
	end
endmodule

// ==== dv/tb_motion_card_supervisor.sv ====
// Self-checking testbench of the motion card supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
	end end
module tb_motion_card_supervisor
	import mcs_pkg::*;
;
	localparam int unsigned BH = 8;
	localparam int unsigned PP = 16;
	localparam int LIMIT = 6000;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [5:0] joint_lower_limit = 6'h00;
	logic [5:0] joint_upper_limit = 6'h00;
	logic [5:0] joint_reference_switch = 6'h00;
	logic [1:0] estop_in = 2'h0;
	logic power_fault = 1'b0, can_frame = 1'b0, can_buffer_full = 1'b0;
	logic host_bus_error = 1'b0;
	logic [6:0] power_enable;
	logic node_answer, node_poll;
	logic [3:0] node_answer_addr, node_poll_addr;
	logic led_can, led_rs485, host_activity_indicator, led_boot, led_error;
	logic [15:0] mask = 16'h0005;
	logic [3:0] dly = 4'h1;
	logic [4:0] leds, any1, all1;
	logic [31:0] rd;
	logic [15:0] frz;
	logic err;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	assign leds = {led_can, led_rs485, host_activity_indicator, led_boot,
		led_error};
	////////////////////////////////////////////////////////////////////////
	mcs_top #(.BLINK_HALF(BH), .POLL_PERIOD(PP)) uut (.pclk, .presetn, .ce,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .joint_lower_limit, .joint_upper_limit,
		.joint_reference_switch, .estop_in, .power_fault, .power_enable,
		.can_frame, .can_buffer_full, .host_bus_error, .node_answer,
		.node_answer_addr, .node_poll, .node_poll_addr, .led_can,
		.led_rs485, .host_activity_indicator, .led_boot, .led_error);
	mcs_node_model nodes (.pclk, .presetn, .node_poll, .node_poll_addr,
		.present_mask(mask), .delay(dly), .node_answer, .node_answer_addr);
	always #2.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, e)
	endtask
	task automatic watch;
		any1 = 5'h00;
		all1 = 5'h1F;
		tick(2);
		repeat (2 * BH + 4) begin
			@(posedge pclk);
			any1 |= leds;
			all1 &= leds;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		`CHK(power_enable, 7'h00)
		watch();
		`CHK(all1[1], 1'b1)
		`CHK(any1[0], 1'b0)
		`CHK({any1[3], all1[3]}, 2'b10)
		rd_chk(ADDR_CTRL, 32'h0000_0000);
		rd_chk(ADDR_TIMEOUT, TIMEOUT_RESET);
		rd_chk(8'h18, 32'h0000_0000);
		`CHK(err, 1'b1)
		$display("test reset done");
	endtask
	task automatic t_inputs;
		logic [19:0] p;
		for (int i = 0; i < 2; i++) begin
			p = i ? 20'hBCA95 : 20'h4356A;
			{estop_in, joint_reference_switch, joint_upper_limit,
				joint_lower_limit} <= p;
			tick(3);
			rd_chk(ADDR_INPUTS, {12'h000, p});
			rd_chk(ADDR_INPUTS_N, {12'h000, ~p});
		end
		$display("test inputs done");
	endtask
	task automatic t_watchdog;
		apb(1'b1, ADDR_TIMEOUT, 32'h0000_0014);
		rd_chk(ADDR_TIMEOUT, 32'h0000_0014);
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		repeat (6) begin
			tick(10);
			apb(1'b0, ADDR_INPUTS, 32'h0000_0000);
		end
		`CHK(power_enable, 7'h7F)
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[ST_WD_EXP], 1'b0)
		tick(30);
		`CHK(power_enable, 7'h00)
		`CHK(led_error, 1'b1)
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[ST_WD_EXP], 1'b1)
		tick(40);
		apb(1'b0, ADDR_INPUTS, 32'h0000_0000);
		tick(2);
		`CHK(power_enable, 7'h00)
		apb(1'b1, ADDR_CTRL, 32'h0000_0002);
		tick(40);
		`CHK(power_enable, 7'h7F)
		power_fault <= 1'b1;
		tick(4);
		`CHK(power_enable, 7'h00)
		power_fault <= 1'b0;
		tick(4);
		`CHK(power_enable, 7'h7F)
		$display("test watchdog done");
	endtask
	task automatic t_leds;
		apb(1'b1, ADDR_CTRL, 32'h0000_0006);
		watch();
		`CHK({any1[2], all1[2]}, 2'b10)
		`CHK(any1[4], 1'b0)
		can_buffer_full <= 1'b1;
		watch();
		`CHK(all1[4], 1'b1)
		can_buffer_full <= 1'b0;
		can_frame <= 1'b1;
		watch();
		`CHK({any1[4], all1[4]}, 2'b10)
		can_frame <= 1'b0;
		host_bus_error <= 1'b1;
		tick(1);
		host_bus_error <= 1'b0;
		watch();
		`CHK({any1[0], all1[0]}, 2'b10)
		apb(1'b1, ADDR_CTRL, 32'h0000_0012);
		watch();
		`CHK(any1[0], 1'b0)
		`CHK(any1[2], 1'b0)
		ce <= 1'b0;
		tick(1);
		frz = {leds, power_enable, node_poll_addr};
		tick(20);
		`CHK({leds, power_enable, node_poll_addr}, frz)
		ce <= 1'b1;
		$display("test indicators done");
	endtask
	task automatic t_nodes;
		tick(2 * 16 * PP);
		rd_chk(ADDR_NODES, 32'h0000_0005);
		watch();
		`CHK(all1[3], 1'b1)
		dly <= 4'hC;
		mask <= 16'h0001;
		tick(4 * 16 * PP);
		rd_chk(ADDR_NODES, 32'h0004_0001);
		watch();
		`CHK(any1[3], 1'b0)
		apb(1'b1, ADDR_CTRL, 32'h0000_000A);
		rd_chk(ADDR_NODES, 32'h0000_0000);
		rd_chk(ADDR_STATUS, 32'h0000_0014);
		$display("test expander done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(3);
		presetn <= 1'b1;
		tick(2);
		t_reset();
		t_inputs();
		t_watchdog();
		t_leds();
		t_nodes();
		tally_and_finish();
	end
endmodule
